/* hw/brmc_buck_mode_ctrl.v */
// buck regulator switching mode, set point and power state control
// Function
// (R1) supply undervoltage sends power state to coin cell
// (R2) overcurrent beyond 8.0 ms raises fault flag
// (R3) soft-start steps pulse-frequency, pulse-skip, then PWM
// (R4) 3.0 ms after regulation use selected mode
// (R5) mode re-evaluated on writes, standby, sleep, load
// (R6) off mode disables regulator, enables output discharge
// (R7) PULSE_FREQUENCY_MODE, PWM fixed; auto mode follows load
// (R8) codes 0,1,3,4 map; reserved codes listed
// (R9) codes 5,6,8,C,D map normal/standby pairs
// (R10) standby uses standby set point and mode
// (R11) leaving standby restores normal mode, set point
// (R12) normal and standby set points share encoding
// (R13) turn-off: keep bit sleeps, others turn off
// (R14) sleep uses sleep set point, pulse-frequency mode
// (R15) turn-on ends sleep; kept regulators stay enabled
// (R16) unkept regulators restart at slot with defaults
// (R17) first pair sleep point 6 bits, others 7
// (R18) standby input low normal, high standby set point
// (R19) overcurrent counter restarts when condition clears
// (R20) fault flag latched until software clears it
// (R21) reserved mode codes treated as off
`include "brmc_consts.vh"
module brmc_buck_mode_ctrl #(
  parameter NBUCK = 3,
  parameter OC_CYC = `BRMC_OC_TIME_US * `BRMC_CLK_MHZ,
  parameter HOLD_CYC = `BRMC_HOLD_TIME_US * `BRMC_CLK_MHZ,
  parameter SS_STEP_CYC = `BRMC_SS_STEP_CYC,
  parameter SLOT_CYC = `BRMC_SLOT_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // axi4-lite write
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready_r,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready_r,
  output reg [1:0] bresp_r,
  output reg bvalid_r,
  input wire bready,
  // axi4-lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready_r,
  output reg [31:0] rdata_r,
  output reg [1:0] rresp_r,
  output reg rvalid_r,
  input wire rready,
  // power events
  input wire pwrOnEvt,
  input wire pwrOffEvt,
  input wire mainSupplyLow,
  input wire standbyIn,
  // regulator feedback
  input wire [NBUCK-1:0] ocLimit,
  input wire [NBUCK-1:0] inRegulation,
  input wire [NBUCK-1:0] loadHeavy,
  // regulator control
  output wire [NBUCK-1:0] regEnable,
  output wire [NBUCK-1:0] dischargeEn,
  output wire [NBUCK-1:0] pwmOn,
  output wire [2*NBUCK-1:0] swMode,
  output wire [7*NBUCK-1:0] setpoint,
  output reg faultIrq_r,
  output reg [1:0] pwrState_r
);
  localparam PS_OFF = 2'h0;
  localparam PS_ON = 2'h1;
  localparam PS_SLEEP = 2'h2;
  localparam PS_COIN = 2'h3;
  localparam SS_IDLE = 3'h0;
  localparam SS_PFM = 3'h1;
  localparam SS_APS = 3'h2;
  localparam SS_PWM = 3'h3;
  localparam SS_HOLD = 3'h4;
  localparam SS_RUN = 3'h5;
  localparam [18:0] OC_LIM = OC_CYC;
  localparam [17:0] HOLD_LIM = HOLD_CYC;
  localparam [17:0] STEP_LIM = SS_STEP_CYC;
  localparam [15:0] SEQ_LIM = NBUCK * SLOT_CYC;

  function [1:0] decodeMode;
    input [3:0] code;
    input stby;
    begin
      case (code)
        4'h1: decodeMode = stby ? `BRMC_SW_OFF : `BRMC_SW_PWM; // R8
        4'h3: decodeMode = stby ? `BRMC_SW_OFF : `BRMC_SW_PFM; // R8
        4'h4: decodeMode = stby ? `BRMC_SW_OFF : `BRMC_SW_APS; // R8
        4'h5: decodeMode = `BRMC_SW_PWM; // R9
        4'h6: decodeMode = stby ? `BRMC_SW_APS : `BRMC_SW_PWM; // R9
        4'h8: decodeMode = `BRMC_SW_APS; // R9
        4'hC: decodeMode = stby ? `BRMC_SW_PFM : `BRMC_SW_APS; // R9
        4'hD: decodeMode = stby ? `BRMC_SW_PFM : `BRMC_SW_PWM; // R9
        default: decodeMode = `BRMC_SW_OFF; // R21
      endcase
    end
  endfunction

  reg [7:0] wAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg awHeld_r;
  reg wHeld_r;
  reg [15:0] seqCnt_r;
  reg [31:0] rdNxt;
  reg rdMapped;
  integer k;
  wire wrDo = awHeld_r & wHeld_r & ~bvalid_r;
  wire wrLane0 = wrDo & wStrb_r[0];
  wire [NBUCK-1:0] keepAll;
  wire [NBUCK-1:0] faultAll;
  wire [NBUCK-1:0] wHitB;
  wire [NBUCK-1:0] rHitB;
  wire [32*NBUCK-1:0] rdBuckAll;
  wire [NBUCK-1:0] faultClr;
  wire wrMapped = (wAddr_r == `BRMC_ADDR_STATUS) |
    (wAddr_r == `BRMC_ADDR_FAULT) | (wAddr_r == `BRMC_ADDR_MODES) |
    (|wHitB);

  assign faultClr = (wrLane0 && wAddr_r == `BRMC_ADDR_FAULT) ?
    wData_r[NBUCK-1:0] : {NBUCK{1'b0}};

  // write channel: address and data taken in either order
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `BRMC_RESP_OKAY;
      wAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready_r)
      begin
        awready_r <= 1'b0;
        awHeld_r <= 1'b1;
        wAddr_r <= awaddr;
      end
      if (wvalid && wready_r)
      begin
        wready_r <= 1'b0;
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end
      if (wrDo)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wrMapped ? `BRMC_RESP_OKAY : `BRMC_RESP_SLVERR;
      end
      if (bvalid_r && bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // read data mux on the incoming address
  always @*
  begin
    rdNxt = 32'h00000000;
    rdMapped = 1'b1;
    case (araddr)
      `BRMC_ADDR_STATUS:
      begin
        rdNxt[1:0] = pwrState_r;
        rdNxt[2] = standbyIn;
        rdNxt[4 +: NBUCK] = regEnable;
      end
      `BRMC_ADDR_FAULT: rdNxt[NBUCK-1:0] = faultAll;
      `BRMC_ADDR_MODES:
      begin
        rdNxt[2*NBUCK-1:0] = swMode;
        rdNxt[16 +: NBUCK] = pwmOn;
      end
      default:
      begin
        rdMapped = |rHitB;
        for (k = 0; k < NBUCK; k = k + 1)
          rdNxt = rdNxt | rdBuckAll[32*k +: 32];
      end
    endcase
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `BRMC_RESP_OKAY;
    end
    else if (arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdNxt;
      rresp_r <= rdMapped ? `BRMC_RESP_OKAY : `BRMC_RESP_SLVERR;
    end
    else if (rvalid_r && rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // power state machine and start-up slot counter
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwrState_r <= PS_OFF;
      seqCnt_r <= 16'h0000;
      faultIrq_r <= 1'b0;
    end
    else
    begin
      faultIrq_r <= |faultAll;
      if (pwrState_r == PS_ON && seqCnt_r != SEQ_LIM)
        seqCnt_r <= seqCnt_r + 16'h0001;
      if (mainSupplyLow)
        pwrState_r <= PS_COIN; // R1
      else
        case (pwrState_r)
          PS_OFF, PS_SLEEP:
            if (pwrOnEvt)
            begin
              pwrState_r <= PS_ON; // R15
              seqCnt_r <= 16'h0000;
            end
          PS_ON:
            if (pwrOffEvt)
              pwrState_r <= (|keepAll) ? PS_SLEEP : PS_OFF; // R13
          PS_COIN: pwrState_r <= PS_OFF;
          default: pwrState_r <= PS_OFF;
        endcase
    end
  end

  genvar i;
  generate
    for (i = 0; i < NBUCK; i = i + 1)
    begin : buck
      localparam [7:0] BASE = `BRMC_ADDR_BUCK0 + i * `BRMC_BUCK_STRIDE;
      localparam [7:0] A_CTRL = BASE + `BRMC_OFF_CTRL;
      localparam [7:0] A_NORM = BASE + `BRMC_OFF_NORM;
      localparam [7:0] A_STBY = BASE + `BRMC_OFF_STBY;
      localparam [7:0] A_SLEEP = BASE + `BRMC_OFF_SLEEP;
      localparam [6:0] SPMASK = (i == 0) ? `BRMC_PAIR_MASK :
        `BRMC_FULL_MASK;
      localparam [15:0] SLOT_I = i * SLOT_CYC;
      reg [3:0] mode_r;
      reg keep_r;
      reg [6:0] norm_r;
      reg [6:0] stby_r;
      reg [6:0] slp_r;
      reg [2:0] ss_r;
      reg [17:0] ssCnt_r;
      reg [18:0] ocCnt_r;
      reg fault_r;
      reg [1:0] sel_r;
      reg en_r;
      reg dis_r;
      reg pwm_r;
      reg [6:0] sp_r;
      reg [1:0] selNxt;
      reg [6:0] spNxt;
      reg [31:0] rdB;
      wire offReq = (pwrState_r == PS_OFF) || (pwrState_r == PS_COIN) ||
        (pwrState_r == PS_SLEEP && !keep_r); // R13
      wire offEdge = offReq && ss_r != SS_IDLE;
      wire startReq = pwrState_r == PS_ON && seqCnt_r >= SLOT_I; // R16

      assign wHitB[i] = wAddr_r == A_CTRL || wAddr_r == A_NORM ||
        wAddr_r == A_STBY || wAddr_r == A_SLEEP;
      assign rHitB[i] = araddr == A_CTRL || araddr == A_NORM ||
        araddr == A_STBY || araddr == A_SLEEP;
      assign keepAll[i] = keep_r;
      assign faultAll[i] = fault_r;
      assign regEnable[i] = en_r;
      assign dischargeEn[i] = dis_r;
      assign pwmOn[i] = pwm_r;
      assign swMode[2*i +: 2] = sel_r;
      assign setpoint[7*i +: 7] = sp_r;
      assign rdBuckAll[32*i +: 32] = rdB;

      always @*
      begin
        rdB = 32'h00000000;
        if (araddr == A_CTRL)
          rdB[`BRMC_KEEP_BIT:0] = {keep_r, mode_r};
        else if (araddr == A_NORM)
          rdB[6:0] = norm_r;
        else if (araddr == A_STBY)
          rdB[6:0] = stby_r;
        else if (araddr == A_SLEEP)
          rdB[6:0] = slp_r;
      end

      // configuration; an unkept turn-off restores the default mode and normal set point
      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          mode_r <= `BRMC_MODE_RST;
          keep_r <= 1'b0;
          norm_r <= `BRMC_NORM_RST & SPMASK;
          stby_r <= `BRMC_STBY_RST & SPMASK;
          slp_r <= `BRMC_SLEEP_RST & SPMASK;
        end
        else
        begin
          if (offEdge)
          begin
            mode_r <= `BRMC_MODE_RST; // R16
            norm_r <= `BRMC_NORM_RST & SPMASK; // R16
          end
          else if (wrLane0 && wAddr_r == A_CTRL)
            mode_r <= wData_r[3:0];
          else if (wrLane0 && wAddr_r == A_NORM)
            norm_r <= wData_r[6:0] & SPMASK; // R12
          if (wrLane0 && wAddr_r == A_CTRL)
            keep_r <= wData_r[`BRMC_KEEP_BIT];
          if (wrLane0 && wAddr_r == A_STBY)
            stby_r <= wData_r[6:0] & SPMASK; // R12
          if (wrLane0 && wAddr_r == A_SLEEP)
            slp_r <= wData_r[6:0] & SPMASK; // R17
        end
      end

      // mode and set point recomputed every cycle from current inputs
      always @*
      begin
        spNxt = norm_r; // R11
        selNxt = `BRMC_SW_OFF;
        case (ss_r)
          SS_PFM: selNxt = `BRMC_SW_PFM; // R3
          SS_APS: selNxt = `BRMC_SW_APS; // R3
          SS_PWM, SS_HOLD: selNxt = `BRMC_SW_PWM; // R3
          SS_RUN:
            if (pwrState_r == PS_SLEEP)
            begin
              selNxt = `BRMC_SW_PFM; // R14
              spNxt = slp_r; // R14
            end
            else if (standbyIn)
            begin
              selNxt = decodeMode(mode_r, 1'b1); // R10
              spNxt = stby_r; // R18
            end
            else
              selNxt = decodeMode(mode_r, 1'b0); // R5
          default: selNxt = `BRMC_SW_OFF;
        endcase
      end

      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ss_r <= SS_IDLE;
          ssCnt_r <= 18'h00000;
          ocCnt_r <= 19'h00000;
          fault_r <= 1'b0;
          sel_r <= `BRMC_SW_OFF;
          en_r <= 1'b0;
          dis_r <= 1'b1;
          pwm_r <= 1'b0;
          sp_r <= 7'h00;
        end
        else
        begin
          sel_r <= selNxt;
          en_r <= selNxt != `BRMC_SW_OFF; // R6
          dis_r <= selNxt == `BRMC_SW_OFF; // R6
          pwm_r <= selNxt == `BRMC_SW_PWM ||
            (selNxt == `BRMC_SW_APS && loadHeavy[i]); // R7
          sp_r <= spNxt;
          if (!ocLimit[i])
            ocCnt_r <= 19'h00000; // R19
          else if (ocCnt_r != OC_LIM)
            ocCnt_r <= ocCnt_r + 19'h00001;
          fault_r <= (ocLimit[i] && ocCnt_r == OC_LIM) | // R2
            (fault_r & ~faultClr[i]); // R20
          ssCnt_r <= ssCnt_r + 18'h00001;
          if (offReq)
            ss_r <= SS_IDLE; // R13
          else
            case (ss_r)
              SS_IDLE:
                if (startReq)
                begin
                  ss_r <= SS_PFM;
                  ssCnt_r <= 18'h00000;
                end
              SS_PFM, SS_APS:
                if (ssCnt_r == STEP_LIM)
                begin
                  ss_r <= ss_r + 3'h1; // R3
                  ssCnt_r <= 18'h00000;
                end
              SS_PWM:
                if (inRegulation[i])
                begin
                  ss_r <= SS_HOLD;
                  ssCnt_r <= 18'h00000;
                end
              SS_HOLD:
                if (ssCnt_r == HOLD_LIM)
                  ss_r <= SS_RUN; // R4
              SS_RUN: ss_r <= SS_RUN; // R15
              default: ss_r <= SS_IDLE;
            endcase
        end
      end
    end
  endgenerate
endmodule

/* hw/brmc_consts.vh */
// constants for the buck regulator mode control block
`ifndef BRMC_CONSTS_VH
`define BRMC_CONSTS_VH
`define BRMC_CLK_MHZ 50
`define BRMC_OC_TIME_US 8000
`define BRMC_HOLD_TIME_US 3000
`define BRMC_SS_STEP_CYC 64
`define BRMC_SLOT_CYC 500
`define BRMC_ADDR_STATUS 8'h00
`define BRMC_ADDR_FAULT 8'h04
`define BRMC_ADDR_MODES 8'h08
`define BRMC_ADDR_BUCK0 8'h20
`define BRMC_BUCK_STRIDE 8'h10
`define BRMC_OFF_CTRL 8'h00
`define BRMC_OFF_NORM 8'h04
`define BRMC_OFF_STBY 8'h08
`define BRMC_OFF_SLEEP 8'h0C
`define BRMC_KEEP_BIT 4
`define BRMC_MODE_RST 4'h8
`define BRMC_NORM_RST 7'h18
`define BRMC_STBY_RST 7'h10
`define BRMC_SLEEP_RST 7'h08
`define BRMC_PAIR_MASK 7'h3F
`define BRMC_FULL_MASK 7'h7F
`define BRMC_SW_OFF 2'h0
`define BRMC_SW_PFM 2'h1
`define BRMC_SW_APS 2'h2
`define BRMC_SW_PWM 2'h3
`define BRMC_RESP_OKAY 2'h0
`define BRMC_RESP_SLVERR 2'h2
`endif

/* dv/brmc_buck_mode_ctrl_asserts.sv */
// checker for the buck mode control block
module brmc_asserts #(
  parameter NBUCK = 3,
  parameter OC_CYC = 20
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // watched ports
  input wire bvalid_r,
  input wire pwrOnEvt,
  input wire mainSupplyLow,
  input wire [NBUCK-1:0] ocLimit,
  input wire [NBUCK-1:0] regEnable,
  input wire [NBUCK-1:0] dischargeEn,
  input wire [NBUCK-1:0] pwmOn,
  input wire [2*NBUCK-1:0] swMode,
  input wire faultIrq_r,
  input wire [1:0] pwrState_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // consecutive overcurrent samples of buck 0
  integer ocCnt_r;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ocCnt_r <= 0;
    else
      ocCnt_r <= ocLimit[0] ? ocCnt_r + 1 : 0;
  end
  coin_low_a: assert property (
    mainSupplyLow |=> pwrState_r == 2'h3) else $error("no coin state");
  fault_timing_a: assert property (
    ocCnt_r == OC_CYC + 1 |=> faultIrq_r) else $error("fault late");
  fault_early_a: assert property (
    $rose(faultIrq_r) |-> $past(ocCnt_r) >= OC_CYC + 1)
    else $error("fault early");
  fault_latch_a: assert property (
    $fell(faultIrq_r) |-> $past(bvalid_r)) else $error("fault dropped");
  start_pfm_a: assert property (
    $rose(regEnable[0]) |-> swMode[1:0] == 2'h1)
    else $error("start not in pfm");
  off_discharge_a: assert property (
    dischargeEn[0] == (swMode[1:0] == 2'h0) && !(regEnable[0] &&
    dischargeEn[0])) else $error("discharge wrong");
  fixed_pwm_a: assert property (
    swMode[1:0] != 2'h2 |-> pwmOn[0] == (swMode[1:0] == 2'h3))
    else $error("pwm state wrong");
  sleep_pfm_a: assert property (
    pwrState_r == 2'h2 && $past(pwrState_r) == 2'h2 &&
    $past(pwrState_r, 2) == 2'h2 && regEnable[0] |-> swMode[1:0] == 2'h1)
    else $error("sleep not pfm");
  off_state_a: assert property (
    pwrState_r == 2'h0 && $past(pwrState_r) == 2'h0 &&
    $past(pwrState_r, 2) == 2'h0 |-> regEnable == 0)
    else $error("enabled while off");
  wake_on_a: assert property (
    pwrState_r == 2'h2 && pwrOnEvt && !mainSupplyLow |=> pwrState_r == 2'h1)
    else $error("no wake");
endmodule
bind brmc_buck_mode_ctrl brmc_asserts #(.NBUCK(NBUCK), .OC_CYC(OC_CYC))
  u_brmc_asserts (.mclk(mclk), .rst_n(rst_n), .bvalid_r(bvalid_r),
  .pwrOnEvt(pwrOnEvt), .mainSupplyLow(mainSupplyLow), .ocLimit(ocLimit),
  .regEnable(regEnable), .dischargeEn(dischargeEn), .pwmOn(pwmOn),
  .swMode(swMode), .faultIrq_r(faultIrq_r), .pwrState_r(pwrState_r));

/* dv/tb_top.sv */
// self-checking bench for the buck mode control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam OC = 20;
  localparam HOLD = 10;
  localparam [63:0] L = 64'h568CD1340279ABEF;
  reg mclk = 1'b0, rst_n = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0;
  reg pwrOnEvt = 1'b0, pwrOffEvt = 1'b0;
  reg mainSupplyLow = 1'b0, standbyIn = 1'b0;
  reg [2:0] ocLimit = 3'h0, loadHeavy = 3'h0, inRegulation = 3'h0;
  wire awready_r, wready_r, bvalid_r, arready_r, rvalid_r, faultIrq_r;
  wire [1:0] bresp_r, rresp_r, pwrState_r;
  wire [31:0] rdata_r;
  wire [2:0] regEnable, dischargeEn, pwmOn;
  wire [5:0] swMode;
  wire [20:0] setpoint;
  integer n_errors = 0, check_count = 0, seed = 32'hB7F2ACBD;
  integer i, j, k, v, sb, sp[12];
  reg [31:0] rd_v;
  reg [3:0] c;
  reg [1:0] q[$];
  always #10 mclk = ~mclk;
  brmc_buck_mode_ctrl #(.NBUCK(3), .OC_CYC(OC), .HOLD_CYC(HOLD),
    .SS_STEP_CYC(3), .SLOT_CYC(5)) u_brmc_buck_mode_ctrl (
    .mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready_r(awready_r), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready_r(wready_r), .bresp_r(bresp_r), .bvalid_r(bvalid_r),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready_r(arready_r), .rdata_r(rdata_r), .rresp_r(rresp_r),
    .rvalid_r(rvalid_r), .rready(rready), .pwrOnEvt(pwrOnEvt),
    .pwrOffEvt(pwrOffEvt), .mainSupplyLow(mainSupplyLow),
    .standbyIn(standbyIn), .ocLimit(ocLimit), .inRegulation(inRegulation),
    .loadHeavy(loadHeavy), .regEnable(regEnable),
    .dischargeEn(dischargeEn), .pwmOn(pwmOn), .swMode(swMode),
    .setpoint(setpoint), .faultIrq_r(faultIrq_r), .pwrState_r(pwrState_r));
  task chk(input [31:0] seen, input [31:0] exp, input string what);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  end
  endtask
  // expected switching mode of a code, normal or standby column
  function [1:0] mexp(input [3:0] m, input s);
    case (m)
      4'h1: mexp = s ? 2'h0 : 2'h3;
      4'h3: mexp = s ? 2'h0 : 2'h1;
      4'h4: mexp = s ? 2'h0 : 2'h2;
      4'h5: mexp = 2'h3;
      4'h6: mexp = s ? 2'h2 : 2'h3;
      4'h8: mexp = 2'h2;
      4'hC: mexp = s ? 2'h1 : 2'h2;
      4'hD: mexp = s ? 2'h1 : 2'h3;
      default: mexp = 2'h0;
    endcase
  endfunction
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
  begin
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready_r)
        awvalid <= 1'b0;
      if (wready_r)
        wvalid <= 1'b0;
    end
    while (!bvalid_r);
    chk(bresp_r, er, "bresp");
    bready <= 1'b0;
  end
  endtask
  task axr(input [7:0] a, input [1:0] er);
  begin
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready_r)
        arvalid <= 1'b0;
    end
    while (!rvalid_r);
    rd_v = rdata_r;
    chk(rresp_r, er, "rresp");
    rready <= 1'b0;
  end
  endtask
  task pulse(input on);
  begin
    @(posedge mclk);
    if (on)
      pwrOnEvt <= 1'b1;
    else
      pwrOffEvt <= 1'b1;
    @(posedge mclk);
    pwrOnEvt <= 1'b0;
    pwrOffEvt <= 1'b0;
  end
  endtask
  task settle;
  begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  end
  endtask
  task wrap_up;
  begin
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 12; i = i + 1)
    begin
      sp[i] = (i % 4 == 1) ? 32'h18 : (i % 4 == 2) ? 32'h10 : 32'h08;
      axr(8'(32 + 4 * i), 2'h0);
      chk(rd_v, sp[i], "reset value");
      if (i % 4)
      begin
        v = $random(seed) & 32'h7F;
        sp[i] = i < 4 ? v & 32'h3F : v;
        axw(8'(32 + 4 * i), v, 2'h0);
        axr(8'(32 + 4 * i), 2'h0);
        chk(rd_v, sp[i], "set point");
      end
    end
    axr(8'h1C, 2'h2);
    chk(rd_v, 32'h0, "unmapped");
    axw(8'h1C, 32'hFF, 2'h2);
    pulse(1'b1);
    k = 0;
    for (j = 0; j < 300; j = j + 1)
    begin
      @(posedge mclk);
      if (j == 30)
        inRegulation <= 3'h7;
      @(negedge mclk);
      if (q.size() == 0 || q[$] !== swMode[1:0])
        q.push_back(swMode[1:0]);
      if (swMode[1:0] === 2'h3 && inRegulation[0])
        k = k + 1;
    end
    v = 0;
    for (j = 0; j < q.size(); j = j + 1)
      v = v * 4 + q[j];
    chk(v, 32'h6E, "soft start order");
    // pwm after regulation: input seen, hold, output register
    chk(k, HOLD + 3, "hold time");
    for (sb = 0; sb < 2; sb = sb + 1)
      for (j = 0; j < (sb ? 16 : 8); j = j + 1)
      begin
        c = L[63 - 4 * j -: 4];
        axw(8'h30, {28'h0, c}, 2'h0);
        standbyIn <= sb[0];
        loadHeavy <= $random(seed);
        settle;
        chk(swMode[3:2], mexp(c, sb[0]), "mode");
        chk(dischargeEn[1], mexp(c, sb[0]) == 2'h0, "discharge");
        if (mexp(c, sb[0]) == 2'h2)
          chk(pwmOn[1], loadHeavy[1], "auto pwm");
        else
          chk(pwmOn[1], mexp(c, sb[0]) == 2'h3, "fixed pwm");
        if (mexp(c, sb[0]) != 2'h0)
          chk(setpoint[13:7], sb ? sp[6] : sp[5], "set point 1");
        chk(setpoint[6:0], sb ? sp[2] : sp[1], "set point 0");
      end
    @(posedge mclk);
    standbyIn <= 1'b0;
    settle;
    chk(swMode[1:0], 2'h2, "mode after standby");
    chk(setpoint[6:0], sp[1], "set point after standby");
    for (k = 0; k < 3; k = k + 1)
    begin
      @(posedge mclk);
      ocLimit <= 3'h1;
      repeat (k == 2 ? OC + 3 : OC) @(posedge mclk);
      ocLimit <= 3'h0;
      settle;
      chk(faultIrq_r, k == 2, "fault");
    end
    axr(8'h04, 2'h0);
    chk(rd_v, 32'h1, "fault flag");
    axw(8'h04, 32'h1, 2'h0);
    settle;
    chk(faultIrq_r, 1'b0, "fault clear");
    axw(8'h20, 32'h18, 2'h0);
    pulse(1'b0);
    settle;
    chk(pwrState_r, 2'h2, "sleep");
    chk(regEnable, 3'h1, "kept bucks");
    chk(swMode[1:0], 2'h1, "sleep mode");
    chk(setpoint[6:0], sp[3], "sleep point");
    axr(8'h30, 2'h0);
    chk(rd_v, 32'h08, "mode reload");
    axr(8'h34, 2'h0);
    chk(rd_v, 32'h18, "set point reload");
    pulse(1'b1);
    k = 0;
    for (j = 0; j < 300; j = j + 1)
    begin
      @(negedge mclk);
      if (regEnable[0] !== 1'b1)
        k = k + 1;
    end
    chk(k, 0, "kept stays on");
    chk(swMode[1:0], 2'h2, "kept normal mode");
    chk(swMode[3:2], 2'h2, "restart mode");
    chk(setpoint[13:7], 7'h18, "restart point");
    chk(setpoint[20:14], 7'h18, "restart point 2");
    @(posedge mclk);
    mainSupplyLow <= 1'b1;
    settle;
    chk(pwrState_r, 2'h3, "coin cell");
    chk(regEnable, 3'h0, "coin off");
    @(posedge mclk);
    mainSupplyLow <= 1'b0;
    settle;
    chk(pwrState_r, 2'h0, "coin exit");
    wrap_up;
  end
endmodule
